// ---- core/mrf_rx_thresh.sv ----
// receive fifo threshold control, top level
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module mrf_rx_thresh #(
    parameter int DW = 8,
    parameter int DEPTH = 64
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    input wire logic [DW-1:0] MAC_DATA_I,
    input wire logic MAC_VALID_I,
    input wire logic MAC_EOP_I,
    input wire logic [3:0] MAC_ERR_I,
    input wire logic CLIENT_RECV_READY_I,
    input wire logic TX_BUSY_I,
    output logic [DW-1:0] CLIENT_DATA_O,
    output logic CLIENT_DATA_VALID_O,
    output logic CLIENT_END_OF_PACKET_O,
    output logic [3:0] CLIENT_FAULT_O,
    output logic RECV_DATA_AVAILABLE_O,
    output logic RECV_NEAR_EMPTY_FLAG_O,
    output logic RECV_NEAR_FULL_FLAG_O,
    output logic XOFF_REQ_O,
    output logic XON_REQ_O,
    output logic IRQ_O
);
    localparam int AW = $clog2(DEPTH);
    localparam int EW = DW + mrf_pkg::META_W;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    function automatic logic [AW:0] bump(input logic [AW:0] p,
        input logic en);
        bump = p + {{AW{1'b0}}, en};
    endfunction

    mrf_fifo_if #(.DW(DW), .AW(AW)) fif ();

    mrf_fifo_mem #(.DW(DW), .DEPTH(DEPTH)) u_mem (
        .clk_i(CORE_CLK_I),
        .fif(fif.mem)
    );

    mrf_level_cmp #(.DEPTH(DEPTH), .AW(AW)) u_cmp (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .fif(fif.cmp)
    );

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    mrf_pkg::mrf_thr_t ae_ff, af_ff, se_ff, sf_ff;
    mrf_pkg::mrf_thr_t nxt_ae, nxt_af, nxt_se, nxt_sf;
    logic disc_ff, nxt_disc;
    logic [mrf_pkg::EV_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, ev;
    logic [31:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq, nf_d_ff;

    logic [AW:0] wr_ptr_ff, rd_ptr_ff, start_ff, eop_cnt_ff;
    logic [AW:0] nxt_wr_ptr, nxt_rd_ptr, nxt_start, nxt_eop_cnt, count;
    logic trunc_ff, nxt_trunc, pend_ff, nxt_pend;
    logic [3:0] pend_err_ff, nxt_pend_err, put_err;
    logic put, put_eop, drop, full, sf_mode, drop_mode;
    logic ev_trunc, ev_ovf;

    logic rd_go, above_ae, head_eop;
    logic [3:0] head_err;
    logic [DW-1:0] data_ff, nxt_data;
    logic dval_ff, nxt_dval, eop_ff, nxt_eop;
    logic [3:0] fault_ff, nxt_fault;

    mrf_pkg::mrf_pause_t ps_ff, nxt_ps;
    logic xoff_ff, nxt_xoff, xon_ff, nxt_xon;

    assign count = wr_ptr_ff - rd_ptr_ff;
    assign full = (count == FULL_CNT);
    assign sf_mode = (sf_ff == '0);
    assign drop_mode = sf_mode && disc_ff;
    assign fif.count = count;
    assign fif.ae = ae_ff;
    assign fif.af = af_ff;
    assign fif.se = se_ff;
    assign fif.sf = sf_ff;
    assign fif.wr_addr = wr_ptr_ff[AW-1:0];
    assign fif.rd_addr = rd_ptr_ff[AW-1:0];

    // ----------------------------------------
    // write side, truncation
    // ----------------------------------------
    always_comb begin
        put = 1'b0;
        put_eop = 1'b0;
        put_err = '0;
        nxt_trunc = trunc_ff;
        nxt_pend = pend_ff;
        nxt_pend_err = pend_err_ff;
        ev_trunc = 1'b0;
        ev_ovf = 1'b0;
        if (pend_ff) begin
            ev_ovf = MAC_VALID_I;
            if (!full) begin
                put = 1'b1;
                put_eop = 1'b1;
                put_err = pend_err_ff;
                nxt_pend = 1'b0;
            end
        end else if (MAC_VALID_I) begin
            if (trunc_ff || (fif.nf && !CLIENT_RECV_READY_I) || full) begin
                nxt_trunc = !MAC_EOP_I;
                if (MAC_EOP_I) begin
                    ev_trunc = 1'b1;
                    if (full) begin
                        nxt_pend = 1'b1;
                        nxt_pend_err = MAC_ERR_I | mrf_pkg::ERR_TRUNC_MASK;
                    end else begin
                        put = 1'b1;
                        put_eop = 1'b1;
                        put_err = MAC_ERR_I | mrf_pkg::ERR_TRUNC_MASK;
                    end
                end
            end else begin
                put = 1'b1;
                put_eop = MAC_EOP_I;
                put_err = MAC_EOP_I ? MAC_ERR_I : 4'h0;
            end
        end
    end

    // ----------------------------------------
    // write pointer, frame commit or drop
    // ----------------------------------------
    always_comb begin
        drop = put && put_eop && drop_mode && (put_err != 4'h0);
        fif.wr_en = put && !drop;
        fif.wr_data = {put_err, put_eop, pend_ff ? {DW{1'b0}} : MAC_DATA_I};
        nxt_wr_ptr = drop ? start_ff : bump(wr_ptr_ff, fif.wr_en);
        nxt_start = (put && put_eop) ? nxt_wr_ptr : start_ff;
    end

    // ----------------------------------------
    // read side, client stream
    // ----------------------------------------
    always_comb begin
        head_eop = fif.rd_data[DW];
        head_err = fif.rd_data[EW-1 -: mrf_pkg::ERR_W];
        above_ae = mrf_pkg::mrf_thr_t'(count) > ae_ff;
        rd_go = (count != '0) && CLIENT_RECV_READY_I
            && ((eop_cnt_ff != '0)
            || (!sf_mode && above_ae));
        nxt_rd_ptr = bump(rd_ptr_ff, rd_go);
        nxt_eop_cnt = bump(eop_cnt_ff, fif.wr_en && put_eop)
            - {{AW{1'b0}}, rd_go && head_eop};
        nxt_dval = rd_go;
        nxt_data = rd_go ? fif.rd_data[DW-1:0] : data_ff;
        nxt_eop = rd_go && head_eop;
        nxt_fault = (rd_go && head_eop) ? head_err : 4'h0;
    end

    // ----------------------------------------
    // pause request sequencing
    // ----------------------------------------
    always_comb begin
        nxt_ps = ps_ff;
        nxt_xoff = 1'b0;
        nxt_xon = 1'b0;
        case (ps_ff)
            mrf_pkg::PS_IDLE: begin
                if (fif.cong) begin
                    nxt_ps = mrf_pkg::PS_XOFF_WAIT;
                end
            end
            mrf_pkg::PS_XOFF_WAIT: begin
                if (!TX_BUSY_I) begin
                    nxt_xoff = 1'b1;
                    nxt_ps = mrf_pkg::PS_CONG;
                end
            end
            mrf_pkg::PS_CONG: begin
                if (!fif.cong) begin
                    nxt_ps = mrf_pkg::PS_XON_WAIT;
                end
            end
            mrf_pkg::PS_XON_WAIT: begin
                if (!TX_BUSY_I) begin
                    nxt_xon = 1'b1;
                    nxt_ps = mrf_pkg::PS_IDLE;
                end
            end
            default: begin
                nxt_ps = mrf_pkg::PS_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers, events, interrupt
    // ----------------------------------------
    always_comb begin
        ev = '0;
        ev[mrf_pkg::EV_NF] = fif.nf && !nf_d_ff;
        ev[mrf_pkg::EV_TRUNC] = ev_trunc;
        ev[mrf_pkg::EV_DROP] = drop;
        ev[mrf_pkg::EV_OVF] = ev_ovf;
        ev[mrf_pkg::EV_XOFF] = nxt_xoff;
        ev[mrf_pkg::EV_XON] = nxt_xon;
        nxt_ae = ae_ff;
        nxt_af = af_ff;
        nxt_se = se_ff;
        nxt_sf = sf_ff;
        nxt_disc = disc_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                mrf_pkg::ADR_AE: nxt_ae = REG_WDATA_I[15:0];
                mrf_pkg::ADR_AF: nxt_af = REG_WDATA_I[15:0];
                mrf_pkg::ADR_SE: nxt_se = REG_WDATA_I[15:0];
                mrf_pkg::ADR_SF: nxt_sf = REG_WDATA_I[15:0];
                mrf_pkg::ADR_CTRL: nxt_disc = REG_WDATA_I[mrf_pkg::CTRL_DISC];
                mrf_pkg::ADR_STAT:
                    nxt_stat = stat_ff & ~REG_WDATA_I[mrf_pkg::EV_W-1:0];
                mrf_pkg::ADR_MASK: nxt_mask = REG_WDATA_I[mrf_pkg::EV_W-1:0];
                default: nxt_stat = nxt_stat;
            endcase
        end
        nxt_stat = nxt_stat | ev;
        nxt_irq = |(nxt_stat & nxt_mask);
        nxt_rdata = '0;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                mrf_pkg::ADR_AE: nxt_rdata[15:0] = ae_ff;
                mrf_pkg::ADR_AF: nxt_rdata[15:0] = af_ff;
                mrf_pkg::ADR_SE: nxt_rdata[15:0] = se_ff;
                mrf_pkg::ADR_SF: nxt_rdata[15:0] = sf_ff;
                mrf_pkg::ADR_CTRL: nxt_rdata[mrf_pkg::CTRL_DISC] = disc_ff;
                mrf_pkg::ADR_STAT: nxt_rdata[mrf_pkg::EV_W-1:0] = stat_ff;
                mrf_pkg::ADR_MASK: nxt_rdata[mrf_pkg::EV_W-1:0] = mask_ff;
                mrf_pkg::ADR_LEVEL: begin
                    nxt_rdata[AW:0] = count;
                    nxt_rdata[mrf_pkg::LVL_FLAGS +: 5] =
                        {trunc_ff, fif.cong, fif.dsav, fif.nf, fif.ne};
                end
                default: nxt_rdata = '0;
            endcase
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ae_ff <= mrf_pkg::RST_AE;
            af_ff <= mrf_pkg::RST_AF;
            se_ff <= mrf_pkg::RST_SE;
            sf_ff <= mrf_pkg::RST_SF;
            disc_ff <= 1'b0;
            stat_ff <= '0;
            mask_ff <= '0;
            rdata_ff <= '0;
            irq_ff <= 1'b0;
            nf_d_ff <= 1'b0;
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            start_ff <= '0;
            eop_cnt_ff <= '0;
            trunc_ff <= 1'b0;
            pend_ff <= 1'b0;
            pend_err_ff <= 4'h0;
            data_ff <= '0;
            dval_ff <= 1'b0;
            eop_ff <= 1'b0;
            fault_ff <= 4'h0;
            ps_ff <= mrf_pkg::PS_IDLE;
            xoff_ff <= 1'b0;
            xon_ff <= 1'b0;
        end else begin
            ae_ff <= nxt_ae;
            af_ff <= nxt_af;
            se_ff <= nxt_se;
            sf_ff <= nxt_sf;
            disc_ff <= nxt_disc;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            nf_d_ff <= fif.nf;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            start_ff <= nxt_start;
            eop_cnt_ff <= nxt_eop_cnt;
            trunc_ff <= nxt_trunc;
            pend_ff <= nxt_pend;
            pend_err_ff <= nxt_pend_err;
            data_ff <= nxt_data;
            dval_ff <= nxt_dval;
            eop_ff <= nxt_eop;
            fault_ff <= nxt_fault;
            ps_ff <= nxt_ps;
            xoff_ff <= nxt_xoff;
            xon_ff <= nxt_xon;
        end
    end

    assign REG_RDATA_O = rdata_ff;
    assign IRQ_O = irq_ff;
    assign CLIENT_DATA_O = data_ff;
    assign CLIENT_DATA_VALID_O = dval_ff;
    assign CLIENT_END_OF_PACKET_O = eop_ff;
    assign CLIENT_FAULT_O = fault_ff;
    assign RECV_DATA_AVAILABLE_O = fif.dsav;
    assign RECV_NEAR_EMPTY_FLAG_O = fif.ne;
    assign RECV_NEAR_FULL_FLAG_O = fif.nf;
    assign XOFF_REQ_O = xoff_ff;
    assign XON_REQ_O = xon_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_cong_up;
        ps_ff == mrf_pkg::PS_IDLE && fif.cong ##1 !TX_BUSY_I;
    endsequence

    sequence s_cong_down;
        ps_ff == mrf_pkg::PS_CONG && !fif.cong ##1 !TX_BUSY_I;
    endsequence

    near_empty_a:
        assert property (!above_ae && eop_cnt_ff == '0
            |=> !CLIENT_DATA_VALID_O)
        else $error("read past near-empty level without end of packet");
    eop_drain_a:
        assert property (eop_cnt_ff != '0 && CLIENT_RECV_READY_I
            |=> CLIENT_DATA_VALID_O)
        else $error("stored frame not drained");
    near_full_a:
        assert property (fif.lvl_ok
            && mrf_pkg::mrf_thr_t'(FULL_CNT - count) <= af_ff
            |=> RECV_NEAR_FULL_FLAG_O)
        else $error("near-full flag missing");
    trunc_hold_a:
        assert property (trunc_ff && !pend_ff && MAC_VALID_I && !MAC_EOP_I
            |-> !fif.wr_en ##1 wr_ptr_ff == $past(wr_ptr_ff))
        else $error("write during truncation");
    fault_eop_a:
        assert property (CLIENT_FAULT_O[0] |-> CLIENT_END_OF_PACKET_O)
        else $error("truncation fault without end of packet");
    trunc_inv_a:
        assert property (fif.wr_en && fif.wr_data[EW-mrf_pkg::ERR_W]
            |-> fif.wr_data[EW-1] && fif.wr_data[DW])
        else $error("truncated frame not marked invalid");
    err_drop_a:
        assert property (drop |=> wr_ptr_ff == $past(start_ff)
            && eop_cnt_ff == $past(eop_cnt_ff) - {{AW{1'b0}}, $past(rd_go)
            && $past(head_eop)})
        else $error("errored frame not dropped");
    xoff_req_a:
        assert property (s_cong_up |=> XOFF_REQ_O)
        else $error("xoff not requested");
    xon_req_a:
        assert property (s_cong_down |=> XON_REQ_O)
        else $error("xon not requested");
    sf_valid_a:
        assert property (sf_mode && eop_cnt_ff == '0
            |=> !CLIENT_DATA_VALID_O)
        else $error("valid before whole frame stored");
    pause_idle_a:
        assert property (XOFF_REQ_O || XON_REQ_O |-> $past(TX_BUSY_I) == 1'b0)
        else $error("pause requested while transmitter busy");
endmodule

// ---- core/mrf_pkg.sv ----
// shared constants and types of the receive fifo threshold block
package mrf_pkg;

    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADR_AE = 8'h00;
    localparam logic [7:0] ADR_AF = 8'h04;
    localparam logic [7:0] ADR_SE = 8'h08;
    localparam logic [7:0] ADR_SF = 8'h0c;
    localparam logic [7:0] ADR_CTRL = 8'h10;
    localparam logic [7:0] ADR_STAT = 8'h14;
    localparam logic [7:0] ADR_MASK = 8'h18;
    localparam logic [7:0] ADR_LEVEL = 8'h1c;

    // ----------------------------------------
    // threshold type and reset values
    // ----------------------------------------
    typedef logic [15:0] mrf_thr_t;
    localparam mrf_thr_t RST_AE = 16'h0008;
    localparam mrf_thr_t RST_AF = 16'h0008;
    localparam mrf_thr_t RST_SE = 16'h0010;
    localparam mrf_thr_t RST_SF = 16'h0010;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int CTRL_DISC = 0;
    localparam int EV_W = 6;
    localparam int EV_NF = 0;
    localparam int EV_TRUNC = 1;
    localparam int EV_DROP = 2;
    localparam int EV_OVF = 3;
    localparam int EV_XOFF = 4;
    localparam int EV_XON = 5;
    localparam int LVL_FLAGS = 16;
    localparam int ERR_W = 4;
    localparam logic [3:0] ERR_TRUNC_MASK = 4'h9;
    localparam int META_W = 5;

    typedef enum logic [1:0] {
        PS_IDLE, PS_XOFF_WAIT, PS_CONG, PS_XON_WAIT
    } mrf_pause_t;

endpackage

// ---- core/mrf_fifo_if.sv ----
// carrier between control, storage and level compare
`timescale 1ns/1ps
interface mrf_fifo_if #(
    parameter int DW = 8,
    parameter int AW = 6
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW+mrf_pkg::META_W-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW+mrf_pkg::META_W-1:0] rd_data;
    logic [AW:0] count;
    mrf_pkg::mrf_thr_t ae;
    mrf_pkg::mrf_thr_t af;
    mrf_pkg::mrf_thr_t se;
    mrf_pkg::mrf_thr_t sf;
    logic ne;
    logic nf;
    logic dsav;
    logic cong;
    logic lvl_ok;

    modport ctl (output wr_en, wr_addr, wr_data, rd_addr, count, ae, af,
        se, sf, input rd_data, ne, nf, dsav, cong, lvl_ok);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
    modport cmp (input count, ae, af, se, sf,
        output ne, nf, dsav, cong, lvl_ok);
endinterface

// ---- core/mrf_fifo_mem.sv ----
// fifo entry storage, flip-flop array
`timescale 1ns/1ps
module mrf_fifo_mem #(
    parameter int DW = 8,
    parameter int DEPTH = 64
) (
    input wire logic clk_i,
    mrf_fifo_if.mem fif
);
    localparam int EW = DW + mrf_pkg::META_W;

    logic [EW-1:0] mem_ff [DEPTH];

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (fif.wr_en) begin
            mem_ff[fif.wr_addr] <= fif.wr_data;
        end
    end

    assign fif.rd_data = mem_ff[fif.rd_addr];
endmodule

// ---- core/mrf_level_cmp.sv ----
// level against threshold compare, registered flags
`timescale 1ns/1ps
module mrf_level_cmp #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    mrf_fifo_if.cmp fif
);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic ne_ff, nf_ff, dsav_ff, cong_ff, ok_ff;
    logic nxt_ne, nxt_nf, nxt_dsav, nxt_cong;
    mrf_pkg::mrf_thr_t used, free;

    // ----------------------------------------
    // compare
    // ----------------------------------------
    always_comb begin
        used = mrf_pkg::mrf_thr_t'(fif.count);
        free = mrf_pkg::mrf_thr_t'(FULL_CNT - fif.count);
        nxt_ne = ok_ff && (used <= fif.ae);
        nxt_nf = ok_ff && (free <= fif.af);
        nxt_dsav = ok_ff && (fif.sf != '0) && (used >= fif.sf);
        nxt_cong = ok_ff && (fif.se != '0) && (used >= fif.se);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ne_ff <= 1'b0;
            nf_ff <= 1'b0;
            dsav_ff <= 1'b0;
            cong_ff <= 1'b0;
            ok_ff <= 1'b0;
        end else begin
            ne_ff <= nxt_ne;
            nf_ff <= nxt_nf;
            dsav_ff <= nxt_dsav;
            cong_ff <= nxt_cong;
            ok_ff <= 1'b1;
        end
    end

    assign fif.ne = ne_ff;
    assign fif.nf = nf_ff;
    assign fif.dsav = dsav_ff;
    assign fif.cong = cong_ff;
    assign fif.lvl_ok = ok_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    flags_reset_a:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            !ok_ff |=> !ne_ff && !nf_ff && !dsav_ff)
        else $error("level flag raised before first compare");
    dsav_sf_a:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            fif.sf == '0 |=> !dsav_ff)
        else $error("data available raised in store and forward");
    dsav_set_a:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            ok_ff && fif.sf != '0 && used >= fif.sf |=> dsav_ff)
        else $error("data available missing at read start level");
endmodule

// ---- verification/mrf_client_model.sv ----
// receiving client model: ready with optional random stalls
`timescale 1ns/1ps
module mrf_client_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic hold_i,
    input wire logic slow_i,
    output logic ready_o
);
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !hold_i && !(slow_i && $urandom_range(1, 0) == 0);
        end
    end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the receive fifo threshold block
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, mv = 0, me = 0, busy = 0;
    logic hold = 1, slow = 0, rdy, vld, eop, dav, ne, nf, xoff, xon, irq;
    logic [7:0] adr = 0, md = 0, cd;
    logic [31:0] wd = 0, rdat;
    logic [3:0] merr = 0, flt;
    logic [31:0] rq[$], dq[$], fq[$];
    logic rd_seen = 0, part = 0;
    int failures = 0, comparisons = 0, cyc = 0, nxoff = 0, nxon = 0;
    always #50 clk = ~clk;
    mrf_rx_thresh #(.DW(8), .DEPTH(16)) DUT (.CORE_CLK_I(clk),
        .RST_B_I(rst_b), .REG_ADDR_I(adr), .REG_WDATA_I(wd), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdat), .MAC_DATA_I(md), .MAC_VALID_I(mv),
        .MAC_EOP_I(me), .MAC_ERR_I(merr), .CLIENT_RECV_READY_I(rdy),
        .TX_BUSY_I(busy), .CLIENT_DATA_O(cd), .CLIENT_DATA_VALID_O(vld),
        .CLIENT_END_OF_PACKET_O(eop), .CLIENT_FAULT_O(flt),
        .RECV_DATA_AVAILABLE_O(dav), .RECV_NEAR_EMPTY_FLAG_O(ne),
        .RECV_NEAR_FULL_FLAG_O(nf), .XOFF_REQ_O(xoff), .XON_REQ_O(xon),
        .IRQ_O(irq));
    mrf_client_model CLIENT (.clk_i(clk), .rst_b_i(rst_b), .hold_i(hold),
        .slow_i(slow), .ready_o(rdy));
    // ----------------------------------------
    // compare and close
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // output watcher
    // ----------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            results();
        end
        nxoff += xoff;
        nxon += xon;
        if (rd_seen) chk(rdat, rq.pop_front());
        rd_seen <= rd;
        if (vld === 1'b1) begin
            chk({31'h0, part}, 32'h0);
            if (dq.size() > 0) chk({24'h0, cd}, dq.pop_front());
            if (eop === 1'b1) begin
                chk({28'h0, flt}, fq.size() ? fq.pop_front() : '1);
            end
        end
    end
    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1; adr <= a; wd <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1; adr <= a; rq.push_back(e);
        @(posedge clk);
        rd <= 0;
    endtask
    task automatic send(input int n, input logic [3:0] e, input bit keep,
        input bit last = 1'b1);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            @(posedge clk);
            mv <= 1; md <= d; me <= last && (i == n - 1); merr <= e;
            if (keep) dq.push_back({24'h0, d});
        end
        @(posedge clk);
        mv <= 0; me <= 0; part <= 0;
    endtask
    task automatic drain();
        hold <= 0;
        for (int i = 0; i < 100 && fq.size() > 0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk(fq.size(), 0);
        chk(dq.size(), 0);
        hold <= 1;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'habdd6f3a));
        repeat (6) @(posedge clk);
        chk({ne, nf, dav}, 3'b000);
        rst_b <= 1;
        @(posedge clk);
        chk({ne, nf, dav}, 3'b000);
        rreg(8'h00, 32'h8); rreg(8'h04, 32'h8); rreg(8'h08, 32'h10);
        rreg(8'h0c, 32'h10); rreg(8'h10, 0); rreg(8'h14, 0);
        rreg(8'h18, 0); rreg(8'h1c, 32'h10000); rreg(8'h20, 0);
        $display("test registers done");
        wreg(8'h0c, 0);
        part <= 1;
        fq.push_back(0);
        slow <= 1; hold <= 0;
        send(5, 4'h0, 1);
        chk(dav, 0);
        drain();
        slow <= 0;
        wreg(8'h10, 1);
        send(4, 4'h4, 0);
        repeat (6) @(posedge clk);
        hold <= 0;
        repeat (8) @(posedge clk);
        hold <= 1;
        wreg(8'h18, 32'h3f);
        @(negedge clk);
        chk(irq, 1);
        rreg(8'h14, 32'h4);
        wreg(8'h14, 32'h3f);
        @(negedge clk);
        chk(irq, 0);
        $display("test store and forward done");
        wreg(8'h0c, 4);
        send(6, 4'h0, 1, 0);
        chk({dav, ne}, 2'b11);
        hold <= 0;
        repeat (6) @(posedge clk);
        chk(dq.size(), 6);
        fq.push_back(0);
        send(1, 4'h0, 1);
        drain();
        $display("test cut through done");
        wreg(8'h08, 6);
        busy <= 1;
        send(14, 4'h2, 0);
        chk(nf, 1);
        chk(nxoff, 0);
        busy <= 0;
        repeat (4) @(posedge clk);
        chk(nxoff, 1);
        fq.push_back(32'hb);
        drain();
        chk(nxon, 1);
        rreg(8'h14, 32'h33);
        rreg(8'h1c, 32'h10000);
        $display("test truncation and pause done");
        results();
    end
endmodule
